// ==== core/tps_pkg.sv ====
// tps_pkg: shared constants, register map and types of the two-port sram block
// assumes one system clock; all user-side inputs are synchronous to it
package tps_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int TPS_HALF_W = 9;
  localparam int TPS_DATA_W = 18;
  localparam int TPS_LOC_W = 9;
  localparam int TPS_ROW_W = 8;
  localparam int TPS_ROWS = 256;
  localparam int TPS_CNT_W = 13;
  localparam logic [TPS_CNT_W-1:0] TPS_LOAD_BITS = 13'h1200;
  localparam logic [4:0] TPS_LAST_BIT = 5'h11;
  localparam logic [1:0] TPS_LANE_LO = 2'h1;
  localparam logic [1:0] TPS_LANE_HI = 2'h2;
  localparam logic [1:0] TPS_LANE_BOTH = 2'h3;

  // ----------------------------------------
  // width codes
  // ----------------------------------------
  localparam logic [1:0] TPS_W9 = 2'h1;
  localparam logic [1:0] TPS_W18 = 2'h2;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int TPS_ADR_W = 8;
  localparam logic [7:0] TPS_REG_CTRL = 8'h00;
  localparam logic [7:0] TPS_REG_STATUS = 8'h04;
  localparam logic [7:0] TPS_REG_RDWORD = 8'h08;
  localparam int TPS_CTRL_WSEL = 0;
  localparam int TPS_CTRL_RW = 2;
  localparam int TPS_CTRL_PIPE = 4;
  localparam int TPS_CTRL_WEN_HI = 5;
  localparam int TPS_CTRL_REN_HI = 6;
  localparam int TPS_CTRL_WFALL = 7;
  localparam int TPS_CTRL_RFALL = 8;
  localparam int TPS_CTRL_ANW = 9;
  localparam int TPS_CTRL_BNW = 11;
  localparam logic [31:0] TPS_CTRL_RESET = 32'h0000_1e05;
  localparam logic [31:0] TPS_CTRL_MASK = 32'h0000_1fff;
  localparam int TPS_ST_BAD = 0;
  localparam int TPS_ST_LOAD = 1;
  localparam int TPS_ST_CNT = 16;

  typedef enum logic [2:0] {
    TPS_BUS_IDLE = 3'h1,
    TPS_BUS_ACK = 3'h2,
    TPS_BUS_GAP = 3'h4
  } tps_bus_t;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  function automatic logic [TPS_HALF_W-1:0] tps_narrow_mask(input logic [1:0] nw);
    unique case (nw)
      2'h0: tps_narrow_mask = 9'h001;
      2'h1: tps_narrow_mask = 9'h003;
      2'h2: tps_narrow_mask = 9'h00f;
      2'h3: tps_narrow_mask = 9'h1ff;
    endcase
  endfunction : tps_narrow_mask

  function automatic logic tps_width_ok(input logic [1:0] code);
    tps_width_ok = (code == TPS_W9) || (code == TPS_W18);
  endfunction : tps_width_ok

endpackage : tps_pkg

// ==== core/tps_mem_if.sv ====
// tps_mem_if: request and answer wires between the control logic and the array
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface tps_mem_if;
  import tps_pkg::*;
  logic we;
  logic [1:0] lane;
  logic [TPS_ROW_W-1:0] write_location;
  logic [TPS_DATA_W-1:0] wdata;
  logic re;
  logic [TPS_ROW_W-1:0] read_location;
  logic [TPS_DATA_W-1:0] rdata;

  modport ctrl (output we, output lane, output write_location, output wdata, output re, output read_location, input rdata);
  modport array (input we, input lane, input write_location, input wdata, input re, input read_location, output rdata);
endinterface : tps_mem_if

// ==== core/tps_sram_array.sv ====
// tps_sram_array: 256 rows of two 9-bit lanes, lane-writable, registered read
// assumes the control logic never resets it; contents survive every reset
`timescale 1ns/1ps
module tps_sram_array
  import tps_pkg::*;
#(
  parameter int ROWS = TPS_ROWS
) (
  input wire logic clk_i,
  tps_mem_if.array mem
);

  logic [TPS_DATA_W-1:0] rdata_w;
  logic [TPS_DATA_W-1:0] rdata_d;
  logic [TPS_DATA_W-1:0] rdata_q;

  // ----------------------------------------
  // lane writes, one array per lane so each has a single writer
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_lane
    logic [TPS_HALF_W-1:0] cells [ROWS];
    always_ff @(posedge clk_i) begin
      if (mem.we && mem.lane[g]) begin
        cells[mem.write_location] <= mem.wdata[g*TPS_HALF_W +: TPS_HALF_W];
      end
    end
    assign rdata_w[g*TPS_HALF_W +: TPS_HALF_W] = cells[mem.read_location];
  end

  // ----------------------------------------
  // read
  // ----------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (mem.re) begin
      rdata_d = rdata_w;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_q <= rdata_d;
  end

  assign mem.rdata = rdata_q;

endmodule : tps_sram_array

// ==== core/tps_two_port_sram.sv ====
// tps_two_port_sram: two-port sram block with wishbone control and serial preload
// assumes write/read clocks and user inputs are sampled levels synchronous to clk_i
`timescale 1ns/1ps
module tps_two_port_sram
  import tps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [TPS_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic blk_reset_n_i,
  input wire logic write_clk_i,
  input wire logic write_en_i,
  input wire logic [TPS_LOC_W-1:0] write_location_i,
  input wire logic [TPS_DATA_W-1:0] write_data_bus_i,
  input wire logic read_clk_i,
  input wire logic read_en_i,
  input wire logic [TPS_LOC_W-1:0] read_location_i,
  input wire logic jtag_sel_i,
  input wire logic jtag_shift_i,
  input wire logic jtag_tdi_i,
  output logic [TPS_DATA_W-1:0] read_data_o,
  output logic [TPS_HALF_W-1:0] port_a_out_o,
  output logic [TPS_HALF_W-1:0] port_b_out_o
);

  tps_mem_if mif ();

  tps_sram_array #(.ROWS(TPS_ROWS)) u_array (
    .clk_i(clk_i),
    .mem(mif.array)
  );

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  tps_bus_t bus_q, bus_d;
  logic ack_q, ack_d;
  logic [31:0] wb_dat_q, wb_dat_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] status_w;

  // datapath state
  logic wclk_prev_q, wclk_prev_d;
  logic rclk_prev_q, rclk_prev_d;
  logic rd_pend_q, rd_pend_d;
  logic rd_half_q, rd_half_d;
  logic rd_w18_q, rd_w18_d;
  logic [TPS_DATA_W-1:0] hold_q, hold_d;
  logic [TPS_DATA_W-1:0] out_q, out_d;
  logic [TPS_HALF_W-1:0] pa_q, pa_d;
  logic [TPS_HALF_W-1:0] pb_q, pb_d;
  logic [TPS_CNT_W-1:0] ld_cnt_q, ld_cnt_d;
  logic [4:0] ld_bit_q, ld_bit_d;
  logic [TPS_ROW_W-1:0] ld_row_q, ld_row_d;
  logic [TPS_DATA_W-1:0] ld_sh_q, ld_sh_d;

  logic [1:0] wsel, rw;
  logic pipe, wen_hi, ren_hi, wfall, rfall, bad_code;
  logic wedge, redge, wr_go, rd_go, ld_on, ld_act;
  logic [TPS_DATA_W-1:0] rd_word;

  assign wsel = ctrl_q[TPS_CTRL_WSEL +: 2];
  assign rw = ctrl_q[TPS_CTRL_RW +: 2];
  assign pipe = ctrl_q[TPS_CTRL_PIPE];
  assign wen_hi = ctrl_q[TPS_CTRL_WEN_HI];
  assign ren_hi = ctrl_q[TPS_CTRL_REN_HI];
  assign wfall = ctrl_q[TPS_CTRL_WFALL];
  assign rfall = ctrl_q[TPS_CTRL_RFALL];
  assign bad_code = !tps_width_ok(wsel) || !tps_width_ok(rw);
  assign ld_act = jtag_sel_i && (ld_cnt_q != TPS_LOAD_BITS);

  always_comb begin
    status_w = 32'h0;
    status_w[TPS_ST_BAD] = bad_code;
    status_w[TPS_ST_LOAD] = ld_act;
    status_w[TPS_ST_CNT +: TPS_CNT_W] = ld_cnt_q;
  end

  always_comb begin
    bus_d = bus_q;
    ack_d = 1'b0;
    wb_dat_d = wb_dat_q;
    ctrl_d = ctrl_q;
    unique case (bus_q)
      TPS_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_d = TPS_BUS_ACK;
          ack_d = 1'b1;
          if (wb_adr_i == TPS_REG_CTRL) begin
            wb_dat_d = ctrl_q;
          end else if (wb_adr_i == TPS_REG_STATUS) begin
            wb_dat_d = status_w;
          end else if (wb_adr_i == TPS_REG_RDWORD) begin
            wb_dat_d = {14'h0, out_q};
          end else begin
            wb_dat_d = 32'h0;
          end
        end
      end
      TPS_BUS_ACK: begin
        bus_d = TPS_BUS_GAP;
        if (wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == TPS_REG_CTRL)) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              ctrl_d[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
          end
          ctrl_d = ctrl_d & TPS_CTRL_MASK;
        end
      end
      TPS_BUS_GAP: begin
        bus_d = TPS_BUS_IDLE;
      end
      default: begin
        bus_d = TPS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= TPS_BUS_IDLE;
      ack_q <= 1'b0;
      wb_dat_q <= 32'h0;
      ctrl_q <= TPS_CTRL_RESET;
    end else begin
      bus_q <= bus_d;
      ack_q <= ack_d;
      wb_dat_q <= wb_dat_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = wb_dat_q;

  // ----------------------------------------
  // edge detection, write, read and preload
  // ----------------------------------------
  // separate detectors, each with its own polarity select
  assign wedge = (write_clk_i != wclk_prev_q) && (write_clk_i != wfall);
  assign redge = (read_clk_i != rclk_prev_q) && (read_clk_i != rfall);
  assign wr_go = wedge && (write_en_i == wen_hi) && blk_reset_n_i && !bad_code && !jtag_sel_i;
  assign rd_go = redge && (read_en_i == ren_hi) && blk_reset_n_i && !bad_code;
  assign ld_on = ld_act && jtag_shift_i;
  assign rd_word = rd_w18_q ? mif.rdata
                 : {9'h0, rd_half_q ? mif.rdata[17:9] : mif.rdata[8:0]};

  always_comb begin
    wclk_prev_d = write_clk_i;
    rclk_prev_d = read_clk_i;
    mif.we = 1'b0;
    mif.lane = TPS_LANE_BOTH;
    mif.write_location = write_location_i[TPS_ROW_W-1:0];
    mif.wdata = write_data_bus_i;
    ld_cnt_d = jtag_sel_i ? ld_cnt_q : '0;
    ld_bit_d = jtag_sel_i ? ld_bit_q : '0;
    ld_row_d = jtag_sel_i ? ld_row_q : '0;
    ld_sh_d = ld_sh_q;
    if (ld_on) begin
      ld_sh_d = {jtag_tdi_i, ld_sh_q[TPS_DATA_W-1:1]};
      ld_cnt_d = ld_cnt_q + 13'h1;
      ld_bit_d = ld_bit_q + 5'h1;
      if (ld_bit_q == TPS_LAST_BIT) begin
        ld_bit_d = '0;
        ld_row_d = ld_row_q + 8'h1;
        mif.we = 1'b1;
        mif.write_location = ld_row_q;
        mif.wdata = ld_sh_d;
      end
    end else if (wr_go) begin
      mif.we = 1'b1;
      if (wsel == TPS_W9) begin
        mif.write_location = write_location_i[TPS_LOC_W-1:1];
        mif.lane = write_location_i[0] ? TPS_LANE_HI : TPS_LANE_LO;
        mif.wdata = {write_data_bus_i[8:0], write_data_bus_i[8:0]};
      end
    end
    // address bit 8 ignored at full width
    mif.re = rd_go;
    mif.read_location = (rw == TPS_W18) ? read_location_i[TPS_ROW_W-1:0] : read_location_i[TPS_LOC_W-1:1];
    rd_pend_d = rd_go;
    rd_half_d = rd_go ? read_location_i[0] : rd_half_q;
    rd_w18_d = rd_go ? (rw == TPS_W18) : rd_w18_q;
    hold_d = rd_pend_q ? rd_word : hold_q;
    out_d = out_q;
    if (pipe) begin
      if (redge) begin
        out_d = hold_q;
      end
    end else if (rd_pend_q) begin
      out_d = rd_word;
    end
    if (!blk_reset_n_i) begin
      out_d = '0;
      hold_d = '0;
      rd_pend_d = 1'b0;
    end
    pa_d = out_d[8:0] & tps_narrow_mask(ctrl_q[TPS_CTRL_ANW +: 2]);
    pb_d = out_d[17:9] & tps_narrow_mask(ctrl_q[TPS_CTRL_BNW +: 2]);
  end

  // array is never reset here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_half_q <= 1'b0;
      rd_w18_q <= 1'b0;
      hold_q <= '0;
      out_q <= '0;
      pa_q <= '0;
      pb_q <= '0;
      ld_cnt_q <= '0;
      ld_bit_q <= '0;
      ld_row_q <= '0;
      ld_sh_q <= '0;
    end else begin
      wclk_prev_q <= wclk_prev_d;
      rclk_prev_q <= rclk_prev_d;
      rd_pend_q <= rd_pend_d;
      rd_half_q <= rd_half_d;
      rd_w18_q <= rd_w18_d;
      hold_q <= hold_d;
      out_q <= out_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      ld_cnt_q <= ld_cnt_d;
      ld_bit_q <= ld_bit_d;
      ld_row_q <= ld_row_d;
      ld_sh_q <= ld_sh_d;
    end
  end

  assign read_data_o = out_q;
  assign port_a_out_o = pa_q;
  assign port_b_out_o = pb_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_taken;
    rd_go ##1 rd_pend_q;
  endsequence

  sequence s_word_ready;
    rd_pend_q && !pipe && blk_reset_n_i;
  endsequence

  out_reset_a: assert property (!blk_reset_n_i |=> (read_data_o == '0) && (hold_q == '0))
    else $error("output not cleared under block reset");
  no_user_write_a: assert property (!blk_reset_n_i && !jtag_sel_i |-> !mif.we)
    else $error("write while block reset held");
  flow_out_a: assert property (s_word_ready |=> read_data_o == $past(rd_word))
    else $error("flow read data missing");
  read_pend_a: assert property (rd_go && !pipe |-> s_read_taken ##1
                                ($past(pipe) || !$past(blk_reset_n_i) || (read_data_o == $past(rd_word))))
    else $error("flow read not presented");
  pipe_out_a: assert property (redge && pipe && blk_reset_n_i |=> read_data_o == $past(hold_q))
    else $error("pipelined output did not load hold word");
  wide_write_a: assert property (wr_go && !jtag_sel_i && (wsel == TPS_W18) |-> mif.we && (mif.lane == TPS_LANE_BOTH)
                                 && (mif.write_location == write_location_i[7:0]))
    else $error("wide write not issued");
  wen_pol_a: assert property (wedge && (write_en_i != wen_hi) && !jtag_sel_i |-> !mif.we)
    else $error("write with enable inactive");
  nine_read_a: assert property (rd_pend_q && !rd_w18_q |-> rd_word[17:9] == 9'h0)
    else $error("upper read bits not zero at nine-bit width");
  load_stop_a: assert property ((ld_cnt_q == TPS_LOAD_BITS) && jtag_sel_i |=> ld_cnt_q == TPS_LOAD_BITS)
    else $error("preload ran past array size");
  narrow_a_a: assert property ((port_a_out_o & ~tps_narrow_mask($past(ctrl_q[TPS_CTRL_ANW +: 2]))) == 9'h0)
    else $error("port a bits above width set");
  narrow_b_a: assert property ((port_b_out_o & ~tps_narrow_mask($past(ctrl_q[TPS_CTRL_BNW +: 2]))) == 9'h0)
    else $error("port b bits above width set");
  bus_ack_a: assert property ((bus_q == TPS_BUS_IDLE) && wb_cyc_i && wb_stb_i |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not single cycle");

endmodule : tps_two_port_sram

// ==== tb/tps_user_model.sv ====
// tps_user_model: user fabric that strobes the write and read ports
// assumes port clocks are slow levels stepped on clk_i rising edges
`timescale 1ns/1ps
module tps_user_model
  import tps_pkg::*;
(
  input wire logic clk_i,
  output logic write_clk_o,
  output logic write_en_o,
  output logic [TPS_LOC_W-1:0] write_location_o,
  output logic [TPS_DATA_W-1:0] write_data_bus_o,
  output logic read_clk_o,
  output logic read_en_o,
  output logic [TPS_LOC_W-1:0] read_location_o
);
  logic wfall = 1'b0;
  logic rfall = 1'b0;
  logic wen_hi = 1'b0;
  logic ren_hi = 1'b0;
  logic w9 = 1'b1;
  logic r9 = 1'b1;

  initial begin
    write_clk_o = 1'b0;
    write_en_o = 1'b1;
    write_location_o = 9'h1ff;
    write_data_bus_o = 18'h00000;
    read_clk_o = 1'b0;
    read_en_o = 1'b1;
    read_location_o = 9'h1ff;
  end

  // ----------------------------------------
  // port strobes
  // ----------------------------------------
  task automatic wr(input logic [8:0] loc, input logic [17:0] dat);
    logic [17:0] d;
    logic [8:0] a;
    d = w9 ? {9'h000, dat[8:0]} : dat;
    a = w9 ? loc : {1'b0, loc[7:0]};
    @(posedge clk_i);
    write_clk_o <= wfall;
    @(posedge clk_i);
    write_clk_o <= ~wfall;
    write_en_o <= wen_hi;
    write_location_o <= a;
    write_data_bus_o <= d;
    @(posedge clk_i);
    @(posedge clk_i);
    write_clk_o <= wfall;
    write_en_o <= ~wen_hi;
    write_location_o <= ~a;
    write_data_bus_o <= {d[17:9], ~d[8:0]};
  endtask : wr

  task automatic rd(input logic [8:0] loc);
    logic [8:0] a;
    a = r9 ? loc : {1'b0, loc[7:0]};
    @(posedge clk_i);
    read_clk_o <= rfall;
    @(posedge clk_i);
    read_clk_o <= ~rfall;
    read_en_o <= ren_hi;
    read_location_o <= a;
    @(posedge clk_i);
    @(posedge clk_i);
    read_clk_o <= rfall;
    read_en_o <= ~ren_hi;
    read_location_o <= ~a;
    @(posedge clk_i);
  endtask : rd
endmodule : tps_user_model

// ==== tb/tps_two_port_sram_test.sv ====
// tps_two_port_sram_test: bus, preload and port checks of the sram block
// assumes tps_user_model on the user ports and a 25 MHz clock
`timescale 1ns/1ps
module tps_two_port_sram_test
  import tps_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic blk_reset_n_i = 1'b1;
  logic jtag_sel_i = 1'b0;
  logic jtag_shift_i = 1'b0;
  logic jtag_tdi_i = 1'b0;
  logic write_clk_i, write_en_i, read_clk_i, read_en_i, wb_ack_o;
  logic [8:0] write_location_i, read_location_i, port_a_out_o, port_b_out_o;
  logic [17:0] write_data_bus_i, read_data_o;
  logic [31:0] wb_dat_o, rv;
  int err_total = 0;
  int checks = 0;
  int cyc_n = 0;

  always #20 clk_i = ~clk_i;

  tps_two_port_sram dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .blk_reset_n_i, .write_clk_i, .write_en_i, .write_location_i,
    .write_data_bus_i, .read_clk_i, .read_en_i, .read_location_i, .jtag_sel_i, .jtag_shift_i,
    .jtag_tdi_i, .read_data_o, .port_a_out_o, .port_b_out_o);

  tps_user_model um (.clk_i(clk_i), .write_clk_o(write_clk_i), .write_en_o(write_en_i),
    .write_location_o(write_location_i), .write_data_bus_o(write_data_bus_i),
    .read_clk_o(read_clk_i), .read_en_o(read_en_i), .read_location_o(read_location_i));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk

  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(n, 32'h2, "bus ack latency");
  endtask : wb_io

  task automatic set_ctrl(input logic [31:0] v);
    wb_io(1'b1, TPS_REG_CTRL, v);
    um.w9 = (v[1:0] == TPS_W9);
    um.r9 = (v[3:2] == TPS_W9);
    um.wen_hi = v[TPS_CTRL_WEN_HI];
    um.ren_hi = v[TPS_CTRL_REN_HI];
    um.wfall = v[TPS_CTRL_WFALL];
    um.rfall = v[TPS_CTRL_RFALL];
  endtask : set_ctrl

  task automatic rd_chk(input logic [8:0] loc, input logic [17:0] exp);
    um.rd(loc);
    #1;
    chk({14'h0, read_data_o}, {14'h0, exp}, "read word");
  endtask : rd_chk

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_io(1'b0, TPS_REG_CTRL, 32'h0);
    chk(rv, TPS_CTRL_RESET, "ctrl reset");
    wb_io(1'b0, 8'h0c, 32'h0);
    chk(rv, 32'h0, "unmapped read");
    @(posedge clk_i);
    jtag_sel_i <= 1'b1;
    jtag_shift_i <= 1'b1;
    for (int i = 0; i < 4608; i++) begin
      jtag_tdi_i <= i[0];
      @(posedge clk_i);
    end
    jtag_shift_i <= 1'b0;
    wb_io(1'b0, TPS_REG_STATUS, 32'h0);
    chk(rv, {3'h0, TPS_LOAD_BITS, 16'h0}, "load count");
    jtag_sel_i <= 1'b0;
    set_ctrl(32'h0000_1e0a);
    rd_chk(9'h000, 18'h2aaaa);
    rd_chk(9'h0ff, 18'h2aaaa);
    um.wr(9'h005, 18'h3c0a5);
    um.wr(9'h006, 18'h01234);
    fork
      um.wr(9'h007, 18'h2b3c4);
      rd_chk(9'h005, 18'h3c0a5);
    join
    chk({23'h0, port_b_out_o}, 32'h1e0, "port b out");
    rd_chk(9'h007, 18'h2b3c4);
    wb_io(1'b0, TPS_REG_RDWORD, 32'h0);
    chk(rv, 32'h0002_b3c4, "read word register");
    set_ctrl(32'h0000_1e1a);
    um.rd(9'h006);
    rd_chk(9'h005, 18'h01234);
    set_ctrl(32'h0000_1806);
    um.rd(9'h00a);
    #1;
    chk({23'h0, read_data_o[8:0]}, 32'h0a5, "low half");
    chk({31'h0, port_a_out_o[0]}, 32'h1, "port a bit");
    um.rd(9'h00b);
    #1;
    chk({23'h0, read_data_o[8:0]}, 32'h1e0, "high half");
    chk({31'h0, port_a_out_o[0]}, 32'h0, "port a bit");
    set_ctrl(32'h0000_1e0a);
    @(posedge clk_i);
    blk_reset_n_i <= 1'b0;
    um.wr(9'h005, 18'h12345);
    #1;
    chk({14'h0, read_data_o}, 32'h0, "held output");
    chk({23'h0, port_b_out_o}, 32'h0, "held port b");
    @(posedge clk_i);
    blk_reset_n_i <= 1'b1;
    rd_chk(9'h005, 18'h3c0a5);
    set_ctrl(32'h0000_1fea);
    um.wr(9'h009, 18'h15a5a);
    rd_chk(9'h009, 18'h15a5a);
    set_ctrl(32'h0000_1fe5);
    um.wr(9'h013, 18'h000ff);
    um.rd(9'h013);
    #1;
    chk({23'h0, read_data_o[8:0]}, 32'h0ff, "nine-bit write");
    um.rd(9'h012);
    #1;
    chk({23'h0, read_data_o[8:0]}, 32'h05a, "other half kept");
    wrap_up();
  end
endmodule : tps_two_port_sram_test
